// [hdl/ibtq_pkg.sv]
`default_nettype none
package ibtq_pkg;
  // Bus and descriptor widths
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int TAG_W = 16;
  localparam int LEN_W = 24;
  localparam int CNT_W = 16;
  localparam int DEPTH_DEF = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_BURST = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_CMD = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_CAPACITY = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_FILL = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_DROPPED = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_POLICY = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h1C;

  // Field positions
  localparam int CTRL_METHOD_LSB = 0;
  localparam int CTRL_SUBMODE_BIT = 2;
  localparam int CTRL_OPEN_BIT = 3;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_HALT_BIT = 1;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_REM_LSB = 16;

  // Reset and fixed values
  localparam logic [1:0] METHOD_RST = 2'h0;
  localparam logic SUBMODE_RST = 1'h0;
  localparam logic OPEN_RST = 1'h1;
  localparam logic [CNT_W-1:0] BURST_RST = 16'h0001;
  localparam logic [DATA_W-1:0] POLICY_FIFO = 32'h00000000;

  // Release method, user sub-mode and transmitter states
  typedef enum logic [1:0] {
    IBTQ_BASIC = 2'b00,
    IBTQ_AUTO = 2'b01,
    IBTQ_USER = 2'b10
  } ibtq_method_e;
  typedef enum logic {
    IBTQ_CONT = 1'b0,
    IBTQ_BURST = 1'b1
  } ibtq_submode_e;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_OFFER = 2'b01,
    TX_BUSY = 2'b10
  } ibtq_tx_e;
endpackage
`default_nettype wire

// [hdl/ibtq_desc_ring.sv]
`timescale 1ns/1ps
`default_nettype none
module ibtq_desc_ring #(
  parameter int DEPTH = ibtq_pkg::DEPTH_DEF,
  parameter int W = ibtq_pkg::TAG_W + ibtq_pkg::LEN_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Queue operations
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  input wire logic flush,
  // Queue state
  output logic [W-1:0] dout,
  output logic empty,
  output logic [$clog2(DEPTH+1)-1:0] count,
  output logic dropped
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  if (DEPTH < 2) begin : g_bad_depth
    $error("ibtq_desc_ring: DEPTH must be at least 2");
  end

  logic [W-1:0] mem_reg [DEPTH];
  logic [W-1:0] mem_next [DEPTH];
  logic [PTR_W-1:0] head_reg, head_next, tail_reg, tail_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic full, do_pop;

  // Wrapping pointer increment for any depth
  function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p);
    step = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign full = (cnt_reg == CW'(DEPTH));
  assign do_pop = pop && (cnt_reg != '0);

  // Next pointers, storage and count
  always_comb begin
    mem_next = mem_reg;
    head_next = head_reg;
    tail_next = tail_reg;
    cnt_next = cnt_reg;
    dropped = 1'b0;
    if (flush) begin
      head_next = '0;
      tail_next = '0;
      cnt_next = '0;
    end else begin
      if (do_pop) begin
        head_next = step(head_reg);
      end
      if (push) begin
        mem_next[tail_reg] = din;
        tail_next = step(tail_reg);
        if (full && !do_pop) begin
          head_next = step(head_reg);
          dropped = 1'b1;
        end
      end
      if (push && !do_pop && !full) begin
        cnt_next = cnt_reg + 1'b1;
      end else if (!push && do_pop) begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
  end

  // Register the queue
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      head_reg <= '0;
      tail_reg <= '0;
      cnt_reg <= '0;
    end else begin
      head_reg <= head_next;
      tail_reg <= tail_next;
      cnt_reg <= cnt_next;
    end
    mem_reg <= mem_next;
  end

  assign dout = mem_reg[head_reg];
  assign empty = (cnt_reg == '0);
  assign count = cnt_reg;
endmodule
`default_nettype wire

// [hdl/ibtq_release_gate.sv]
`timescale 1ns/1ps
`default_nettype none
module ibtq_release_gate #(
  parameter int CNT_W = ibtq_pkg::CNT_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Mode settings
  input wire logic [1:0] method,
  input wire logic burst_sub,
  input wire logic [CNT_W-1:0] burst_length,
  // Commands and events
  input wire logic go,
  input wire logic halt,
  input wire logic launch,
  input wire logic drop_all,
  // Release state
  output logic allow,
  output logic running,
  output logic [CNT_W-1:0] remaining
);
  logic run_reg, run_next;
  logic [CNT_W-1:0] rem_reg, rem_next;
  logic user_mode;

  assign user_mode = (method == ibtq_pkg::IBTQ_USER);

  // Start, stop and burst countdown
  always_comb begin
    run_next = run_reg;
    rem_next = rem_reg;
    if (drop_all) begin
      run_next = 1'b0;
      rem_next = '0;
    end else if (user_mode && halt) begin
      run_next = 1'b0;
      rem_next = '0;
    end else if (user_mode && go) begin
      if (burst_sub) begin
        rem_next = burst_length;
        run_next = (burst_length != '0);
      end else begin
        run_next = 1'b1;
      end
    end else if (user_mode && burst_sub && launch && run_reg) begin
      rem_next = rem_reg - 1'b1;
      if (rem_reg == CNT_W'(1)) begin
        run_next = 1'b0;
      end
    end
  end

  // Register the gate state
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      run_reg <= 1'b0;
      rem_reg <= '0;
    end else begin
      run_reg <= run_next;
      rem_reg <= rem_next;
    end
  end

  // Basic and automatic release freely; user waits for start
  assign allow = !user_mode || run_reg;
  assign running = run_reg;
  assign remaining = rem_reg;
endmodule
`default_nettype wire

// [hdl/ibtq_top.sv]
// What this block does
// - Release method is basic, automatic or user.
// - Basic/automatic start sending without waiting further.
// - Basic/automatic send blocks back to back.
// - Slow link: surplus blocks build up queued.
// - Read-only queue capacity value.
// - Read-only current queue fill value.
// - Oldest queued block is always sent next.
// - Full queue: arriving block replaces oldest waiting.
// - Each overwrite bumps the dropped block tally.
// - Block in flight untouched; then next oldest.
// - User method has continuous or burst sub-mode.
// - Continuous streams between start and stop.
// - Burst sends programmed count, then stops.
// - Acquisition start/stop leaves queue untouched.
// - Closing channel empties queue, drops pending.
// - Only finished, sealed blocks enter queue.
// - Stop lets block in flight finish.
// - Start/stop ignored outside user method.
// - Burst length matters only in burst.
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ibtq_top #(
  parameter int DEPTH = ibtq_pkg::DEPTH_DEF,
  parameter int CNT_W = ibtq_pkg::CNT_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [ibtq_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ibtq_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [ibtq_pkg::BE_W-1:0] avs_byteenable,
  output logic [ibtq_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Finished blocks from processing
  input wire logic blk_valid,
  input wire logic blk_sealed,
  input wire logic [ibtq_pkg::TAG_W-1:0] blk_tag,
  input wire logic [ibtq_pkg::LEN_W-1:0] blk_len,
  // Stream channel toward the link layer
  output logic lnk_valid,
  output logic [ibtq_pkg::TAG_W-1:0] lnk_tag,
  output logic [ibtq_pkg::LEN_W-1:0] lnk_len,
  input wire logic lnk_ready,
  input wire logic lnk_block_done,
  output logic lnk_open
);
  localparam int DW = ibtq_pkg::DATA_W;
  localparam int TW = ibtq_pkg::TAG_W;
  localparam int LW = ibtq_pkg::LEN_W;
  localparam int QW = $clog2(DEPTH+1);

  if (CNT_W < 1 || CNT_W > ibtq_pkg::STAT_REM_LSB) begin : g_bad_cnt
    $error("ibtq_top: CNT_W must be 1 to 16");
  end
  if (QW > DW) begin : g_bad_depth
    $error("ibtq_top: DEPTH too large for the fill register");
  end

  // Word-aligned address match
  function automatic logic addr_is(
    input logic [ibtq_pkg::ADDR_W-1:0] a,
    input logic [ibtq_pkg::ADDR_W-1:0] off
  );
    addr_is = (a[ibtq_pkg::ADDR_W-1:2] == off[ibtq_pkg::ADDR_W-1:2]);
  endfunction

  // Byte-lane merge of a write into an old value
  function automatic logic [DW-1:0] merge(
    input logic [DW-1:0] old,
    input logic [DW-1:0] wdata,
    input logic [ibtq_pkg::BE_W-1:0] be
  );
    logic [DW-1:0] r;
    r = old;
    for (int i = 0; i < ibtq_pkg::BE_W; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // Bus handshake state
  logic ack_reg, ack_next;
  logic wait_reg, wait_next;
  logic [DW-1:0] rdata_reg, rdata_next;
  logic req, take_wr;

  // Control registers
  logic [1:0] method_reg, method_next;
  logic sub_reg, sub_next;
  logic open_reg, open_next;
  logic [CNT_W-1:0] burst_reg, burst_next;
  logic go_reg, go_next, halt_reg, halt_next;
  logic [DW-1:0] tally_reg, tally_next;

  // Transmitter
  ibtq_pkg::ibtq_tx_e tx_reg, tx_next;
  logic valid_reg, valid_next;
  logic [TW+LW-1:0] desc_reg, desc_next;

  // Queue and gate wires
  logic push, launch, ring_empty, ring_drop, allow, running;
  logic [TW+LW-1:0] ring_dout;
  logic [QW-1:0] fill;
  logic [CNT_W-1:0] remaining;
  logic [DW-1:0] rd_word, ctrl_word, wr_merge;
  logic [1:0] new_method;

  assign req = avs_read | avs_write;
  assign take_wr = avs_write && ack_reg;

  // Readback of current state
  always_comb begin
    ctrl_word = '0;
    ctrl_word[ibtq_pkg::CTRL_METHOD_LSB +: 2] = method_reg;
    ctrl_word[ibtq_pkg::CTRL_SUBMODE_BIT] = sub_reg;
    ctrl_word[ibtq_pkg::CTRL_OPEN_BIT] = open_reg;
    rd_word = '0;
    if (addr_is(avs_address, ibtq_pkg::OFF_CTRL)) begin
      rd_word = ctrl_word;
    end else if (addr_is(avs_address, ibtq_pkg::OFF_BURST)) begin
      rd_word = DW'(burst_reg);
    end else if (addr_is(avs_address, ibtq_pkg::OFF_CAPACITY)) begin
      rd_word = DW'(DEPTH);
    end else if (addr_is(avs_address, ibtq_pkg::OFF_FILL)) begin
      rd_word = DW'(fill);
    end else if (addr_is(avs_address, ibtq_pkg::OFF_DROPPED)) begin
      rd_word = tally_reg;
    end else if (addr_is(avs_address, ibtq_pkg::OFF_POLICY)) begin
      rd_word = ibtq_pkg::POLICY_FIFO;
    end else if (addr_is(avs_address, ibtq_pkg::OFF_STATUS)) begin
      rd_word[ibtq_pkg::STAT_RUN_BIT] = running;
      rd_word[ibtq_pkg::STAT_BUSY_BIT] = (tx_reg != ibtq_pkg::TX_IDLE);
      rd_word[ibtq_pkg::STAT_REM_LSB +: CNT_W] = remaining;
    end
  end

  // One wait cycle, then the transfer completes
  always_comb begin
    ack_next = req && !ack_reg;
    wait_next = !ack_next;
    rdata_next = rdata_reg;
    if (avs_read && !ack_reg) begin
      rdata_next = rd_word; // Writes leave read data standing
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end else begin
      ack_reg <= ack_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // Register writes and command strobes
  always_comb begin
    method_next = method_reg;
    sub_next = sub_reg;
    open_next = open_reg;
    burst_next = burst_reg;
    go_next = 1'b0;
    halt_next = 1'b0;
    wr_merge = merge(ctrl_word, avs_writedata, avs_byteenable);
    new_method = wr_merge[ibtq_pkg::CTRL_METHOD_LSB +: 2];
    if (take_wr && addr_is(avs_address, ibtq_pkg::OFF_CTRL)) begin
      if (new_method != 2'h3) begin
        method_next = new_method;
      end
      sub_next = wr_merge[ibtq_pkg::CTRL_SUBMODE_BIT];
      open_next = wr_merge[ibtq_pkg::CTRL_OPEN_BIT];
    end
    if (take_wr && addr_is(avs_address, ibtq_pkg::OFF_BURST)) begin
      burst_next = CNT_W'(merge(DW'(burst_reg), avs_writedata,
                                avs_byteenable));
    end
    if (take_wr && addr_is(avs_address, ibtq_pkg::OFF_CMD) &&
        avs_byteenable[0]) begin
      go_next = avs_writedata[ibtq_pkg::CMD_GO_BIT];
      halt_next = avs_writedata[ibtq_pkg::CMD_HALT_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      method_reg <= ibtq_pkg::METHOD_RST;
      sub_reg <= ibtq_pkg::SUBMODE_RST;
      open_reg <= ibtq_pkg::OPEN_RST;
      burst_reg <= ibtq_pkg::BURST_RST;
      go_reg <= 1'b0;
      halt_reg <= 1'b0;
    end else begin
      method_reg <= method_next;
      sub_reg <= sub_next;
      open_reg <= open_next;
      burst_reg <= burst_next;
      go_reg <= go_next;
      halt_reg <= halt_next;
    end
  end

  // Dropped block tally, never cleared by software
  always_comb begin
    tally_next = tally_reg;
    if (ring_drop) begin
      tally_next = tally_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tally_reg <= '0;
    end else begin
      tally_reg <= tally_next;
    end
  end

  // Queue entry: only sealed blocks on an open channel,
  // independent of acquisition state
  assign push = blk_valid && blk_sealed && open_reg;

  // Launch from idle, or straight after the previous block ends
  assign launch = ((tx_reg == ibtq_pkg::TX_IDLE) ||
                   (tx_reg == ibtq_pkg::TX_BUSY && lnk_block_done)) &&
                  !ring_empty && allow && open_reg;

  // Transmitter: offer a descriptor, then wait for block end
  always_comb begin
    tx_next = tx_reg;
    valid_next = valid_reg;
    desc_next = desc_reg;
    unique case (tx_reg)
      ibtq_pkg::TX_IDLE: begin
        if (launch) begin
          desc_next = ring_dout;
          valid_next = 1'b1;
          tx_next = ibtq_pkg::TX_OFFER;
        end
      end
      ibtq_pkg::TX_OFFER: begin
        if (lnk_ready) begin
          valid_next = 1'b0;
          tx_next = ibtq_pkg::TX_BUSY;
        end
      end
      ibtq_pkg::TX_BUSY: begin
        if (launch) begin
          desc_next = ring_dout;
          valid_next = 1'b1;
          tx_next = ibtq_pkg::TX_OFFER;
        end else if (lnk_block_done) begin
          tx_next = ibtq_pkg::TX_IDLE;
        end
      end
      default: begin
        valid_next = 1'b0;
        tx_next = ibtq_pkg::TX_IDLE;
      end
    endcase
    if (!open_reg) begin
      valid_next = 1'b0;
      tx_next = ibtq_pkg::TX_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_reg <= ibtq_pkg::TX_IDLE;
      valid_reg <= 1'b0;
      desc_reg <= '0;
    end else begin
      tx_reg <= tx_next;
      valid_reg <= valid_next;
      desc_reg <= desc_next;
    end
  end

  // Descriptor queue
  ibtq_desc_ring #(
    .DEPTH(DEPTH),
    .W(TW + LW)
  ) u_ring (
    .core_clk(core_clk),
    .nrst(nrst),
    .push(push),
    .din({blk_tag, blk_len}),
    .pop(launch),
    .flush(!open_reg),
    .dout(ring_dout),
    .empty(ring_empty),
    .count(fill),
    .dropped(ring_drop)
  );

  // Release method and user start/stop control
  ibtq_release_gate #(
    .CNT_W(CNT_W)
  ) u_gate (
    .core_clk(core_clk),
    .nrst(nrst),
    .method(method_reg),
    .burst_sub(sub_reg),
    .burst_length(burst_reg),
    .go(go_reg),
    .halt(halt_reg),
    .launch(launch),
    .drop_all(!open_reg),
    .allow(allow),
    .running(running),
    .remaining(remaining)
  );

  // Outputs straight from flops
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign lnk_valid = valid_reg;
  assign lnk_tag = desc_reg[TW+LW-1:LW];
  assign lnk_len = desc_reg[LW-1:0];
  assign lnk_open = open_reg;
endmodule
`default_nettype wire

// [tb/ibtq_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module ibtq_top_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [ibtq_pkg::DATA_W-1:0] avs_readdata,
  // Stream channel
  input wire logic lnk_valid,
  input wire logic [ibtq_pkg::TAG_W-1:0] lnk_tag,
  input wire logic [ibtq_pkg::LEN_W-1:0] lnk_len,
  input wire logic lnk_ready,
  input wire logic lnk_block_done,
  input wire logic lnk_open
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic req;
  logic inflight_reg;
  // Any bus request pending
  assign req = avs_read || avs_write;
  // Block handed to the link and not yet finished or aborted
  always_ff @(posedge core_clk) begin
    if (!nrst || !lnk_open || lnk_block_done) inflight_reg <= 1'b0;
    else if (lnk_valid && lnk_ready) inflight_reg <= 1'b1;
  end
  sequence s_offer;
    lnk_valid && lnk_ready;
  endsequence
  sequence s_wait_one;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_wait_answer;
    req && avs_waitrequest |=> s_wait_one;
  endproperty
  property p_wait_cause;
    !req || !avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_rd_hold;
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
  endproperty
  property p_offer_hold;
    lnk_valid && !lnk_ready |=>
      (lnk_valid && $stable(lnk_tag) && $stable(lnk_len)) || !lnk_open;
  endproperty
  property p_offer_taken;
    s_offer |=> !lnk_valid;
  endproperty
  property p_inflight;
    inflight_reg && !lnk_block_done |=> !lnk_valid || !lnk_open;
  endproperty
  property p_tag_kept;
    !lnk_valid |=> $stable(lnk_tag) || lnk_valid;
  endproperty
  property p_closed;
    !lnk_open [*2] |-> !lnk_valid;
  endproperty
  a_wait_answer: assert property (p_wait_answer)
    else $error("waitrequest did not drop for one cycle");
  a_wait_cause: assert property (p_wait_cause)
    else $error("waitrequest low without a request");
  a_rd_hold: assert property (p_rd_hold)
    else $error("readdata changed without a read");
  a_offer_hold: assert property (p_offer_hold)
    else $error("offer changed before acceptance");
  a_offer_taken: assert property (p_offer_taken)
    else $error("offer stayed after acceptance");
  a_inflight: assert property (p_inflight)
    else $error("new offer while block in flight");
  a_tag_kept: assert property (p_tag_kept)
    else $error("descriptor changed without a launch");
  a_closed: assert property (p_closed)
    else $error("offer while channel closed");
  c_offer: cover property (s_offer);
endmodule
bind ibtq_top ibtq_top_asserts u_chk (.core_clk(core_clk), .nrst(nrst),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .lnk_valid(lnk_valid), .lnk_tag(lnk_tag), .lnk_len(lnk_len),
  .lnk_ready(lnk_ready), .lnk_block_done(lnk_block_done),
  .lnk_open(lnk_open));
`default_nettype wire

// [tb/ibtq_link_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ibtq_link_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Stream channel
  input wire logic lnk_valid,
  input wire logic lnk_open,
  output logic lnk_ready,
  output logic lnk_block_done,
  // Cycles to wait before accepting and before finishing
  input wire logic [7:0] lat
);
  logic busy;
  logic [7:0] cnt;
  // Accept an offer after lat cycles, finish the block lat cycles later
  always_ff @(posedge core_clk) begin
    lnk_ready <= 1'b0;
    lnk_block_done <= 1'b0;
    if (!nrst || !lnk_open) begin
      busy <= 1'b0;
      cnt <= 8'h00;
    end else if (busy) begin
      if (cnt >= lat) begin
        lnk_block_done <= 1'b1;
        busy <= 1'b0;
        cnt <= 8'h00;
      end else cnt <= cnt + 8'h01;
    end else if (lnk_valid && !lnk_ready) begin
      if (cnt >= lat) begin
        lnk_ready <= 1'b1;
        busy <= 1'b1;
        cnt <= 8'h00;
      end else cnt <= cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [tb/ibtq_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module ibtq_top_bench;
  localparam int DEPTH = 4;
  logic core_clk, nrst, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic blk_valid, blk_sealed, lnk_valid, lnk_ready, lnk_block_done, lnk_open;
  logic [15:0] blk_tag, lnk_tag;
  logic [23:0] blk_len, lnk_len;
  logic [7:0] lat;
  logic [5:0] ra [9];
  logic [31:0] re [9];
  logic [39:0] sent_q [$];
  logic [39:0] exp_q [$];
  int errors, compares, n;
  ibtq_top #(.DEPTH(DEPTH)) DUT (.core_clk(core_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .blk_valid(blk_valid), .blk_sealed(blk_sealed), .blk_tag(blk_tag),
    .blk_len(blk_len), .lnk_valid(lnk_valid), .lnk_tag(lnk_tag),
    .lnk_len(lnk_len), .lnk_ready(lnk_ready),
    .lnk_block_done(lnk_block_done), .lnk_open(lnk_open));
  ibtq_link_model u_link (.core_clk(core_clk), .nrst(nrst),
    .lnk_valid(lnk_valid), .lnk_open(lnk_open), .lnk_ready(lnk_ready),
    .lnk_block_done(lnk_block_done), .lat(lat));
  // Clock
  always #4 core_clk = ~core_clk;
  // Record every block the link accepts
  always @(posedge core_clk) begin
    if (nrst && lnk_valid === 1'b1 && lnk_ready === 1'b1)
      sent_q.push_back({lnk_tag, lnk_len});
  end
  // Expected queue fill for a number of waiting blocks
  function automatic int fill_of(input int q);
    return (q > DEPTH) ? DEPTH : q;
  endfunction
  task test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int k;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= 4'hF;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 100);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 100) begin
      errors++;
      test_done();
    end
    @(posedge core_clk);
  endtask
  // Hand n blocks over, one per cycle
  task push(input int cnt, input logic sl);
    logic [15:0] t;
    logic [23:0] l;
    for (int i = 0; i < cnt; i++) begin
      t = 16'($urandom);
      l = 24'($urandom);
      blk_valid <= 1'b1;
      blk_sealed <= sl;
      blk_tag <= t;
      blk_len <= l;
      if (sl) exp_q.push_back({t, l});
      @(posedge core_clk);
    end
    blk_valid <= 1'b0;
    @(posedge core_clk);
  endtask
  task wait_sent(input int cnt);
    int k;
    for (k = 0; k < 3000 && sent_q.size() < cnt; k++) @(posedge core_clk);
    if (k >= 3000) begin
      errors++;
      test_done();
    end
  endtask
  task chk_order(input int cnt);
    for (int i = 0; i < cnt; i++) chk(sent_q[i], exp_q[i]);
    repeat (cnt) void'(exp_q.pop_front());
    sent_q.delete();
  endtask
  task rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000, rd);
    chk(rd, exp);
  endtask
  // Main sequence
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    {avs_read, avs_write, blk_valid, blk_sealed} = 4'h0;
    {avs_address, avs_writedata, avs_byteenable} = '0;
    {blk_tag, blk_len, lat} = '0;
    errors = 0;
    compares = 0;
    void'($urandom(32'h7CBF));
    ra = '{ibtq_pkg::OFF_CTRL, ibtq_pkg::OFF_BURST, ibtq_pkg::OFF_CMD,
      ibtq_pkg::OFF_CAPACITY, ibtq_pkg::OFF_FILL, ibtq_pkg::OFF_DROPPED,
      ibtq_pkg::OFF_POLICY, 6'h20, ibtq_pkg::OFF_STATUS};
    re = '{32'h8, 32'h1, 32'h0, DEPTH, 32'h0, 32'h0,
      ibtq_pkg::POLICY_FIFO, 32'h0, 32'h0};
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    // Reset values, read-only places and an illegal method code
    for (int i = 0; i < 9; i++) rd_chk(ra[i], re[i]);
    chk({31'h0, lnk_open}, 32'h1);
    bus(1'b1, ibtq_pkg::OFF_CAPACITY, 32'h0, rd);
    rd_chk(ibtq_pkg::OFF_CAPACITY, DEPTH);
    bus(1'b1, ibtq_pkg::OFF_CTRL, 32'hB, rd);
    rd_chk(ibtq_pkg::OFF_CTRL, 32'h8);
    $display("test registers done");
    // Automatic: stop and count ignored, unsealed block dropped
    bus(1'b1, ibtq_pkg::OFF_CTRL, 32'h9, rd);
    bus(1'b1, ibtq_pkg::OFF_BURST, 32'h0, rd);
    bus(1'b1, ibtq_pkg::OFF_CMD, 32'h2, rd);
    push(1, 1'b0);
    n = 1 + $urandom % 4;
    push(n, 1'b1);
    wait_sent(n);
    chk_order(n);
    rd_chk(ibtq_pkg::OFF_FILL, 32'h0);
    $display("test automatic done");
    // Basic with a slow link: overflow drops oldest waiting blocks
    bus(1'b1, ibtq_pkg::OFF_CTRL, 32'h8, rd);
    lat <= 8'd60;
    push(DEPTH + 3, 1'b1);
    rd_chk(ibtq_pkg::OFF_FILL, fill_of(DEPTH + 2));
    rd_chk(ibtq_pkg::OFF_DROPPED, DEPTH + 2 - fill_of(DEPTH + 2));
    exp_q.delete(1);
    exp_q.delete(1);
    lat <= 8'd0;
    wait_sent(DEPTH + 1);
    chk_order(DEPTH + 1);
    $display("test overflow done");
    // User continuous: nothing before start, stop lets block finish
    bus(1'b1, ibtq_pkg::OFF_CTRL, 32'hA, rd);
    push(2, 1'b1);
    repeat (30) @(posedge core_clk);
    chk(32'(sent_q.size()), 32'h0);
    bus(1'b1, ibtq_pkg::OFF_CMD, 32'h1, rd);
    wait_sent(2);
    chk_order(2);
    bus(1'b0, ibtq_pkg::OFF_STATUS, 32'h0, rd);
    chk(32'(rd[ibtq_pkg::STAT_RUN_BIT]), 32'h1);
    lat <= 8'd40;
    push(2, 1'b1);
    wait_sent(1);
    bus(1'b1, ibtq_pkg::OFF_CMD, 32'h2, rd);
    repeat (150) @(posedge core_clk);
    chk(32'(sent_q.size()), 32'h1);
    rd_chk(ibtq_pkg::OFF_FILL, 32'h1);
    rd_chk(ibtq_pkg::OFF_STATUS, 32'h0);
    chk_order(1);
    $display("test continuous done");
    // User burst: exactly the programmed count
    bus(1'b1, ibtq_pkg::OFF_CTRL, 32'hE, rd);
    bus(1'b1, ibtq_pkg::OFF_BURST, 32'h2, rd);
    lat <= 8'd0;
    push(3, 1'b1);
    rd_chk(ibtq_pkg::OFF_FILL, 32'h4);
    bus(1'b1, ibtq_pkg::OFF_CMD, 32'h1, rd);
    wait_sent(2);
    repeat (40) @(posedge core_clk);
    chk(32'(sent_q.size()), 32'h2);
    chk_order(2);
    rd_chk(ibtq_pkg::OFF_FILL, 32'h2);
    rd_chk(ibtq_pkg::OFF_STATUS, 32'h0);
    $display("test burst done");
    // Closing the channel flushes the queue
    bus(1'b1, ibtq_pkg::OFF_CTRL, 32'h6, rd);
    rd_chk(ibtq_pkg::OFF_FILL, 32'h0);
    chk({31'h0, lnk_open}, 32'h0);
    exp_q.delete();
    bus(1'b1, ibtq_pkg::OFF_CTRL, 32'h8, rd);
    push(1, 1'b1);
    wait_sent(1);
    chk_order(1);
    $display("test close done");
    test_done();
  end
endmodule
`default_nettype wire
